// [rtl/srwc_pkg.sv]
// Package of constants shared by the SYSREF window capture block
package srwc_pkg;

	// ****************************************************************
	// Register indices (byte address is four times the index)
	// ****************************************************************
	localparam logic [7:0] IDX_EDGE_MAP_LOW  = 8'h2C;
	localparam logic [7:0] IDX_EDGE_MAP_MID  = 8'h2D;
	localparam logic [7:0] IDX_EDGE_MAP_HIGH = 8'h2E;
	localparam logic [7:0] IDX_LINK_CTRL     = 8'h30;
	localparam logic [7:0] IDX_MF_PERIOD     = 8'h31;
	localparam logic [7:0] IDX_LINK_STATUS   = 8'h32;

	// ****************************************************************
	// Tap geometry
	// ****************************************************************
	localparam int EDGE_MAP_BITS = 24;
	localparam int SEL_TAPS      = 16;
	localparam int SEL_W         = 4;
	localparam int MAP_BYTE_W    = 8;

	// ****************************************************************
	// Control register fields and reset values
	// ****************************************************************
	localparam int CTRL_SEL_LSB   = 0;
	localparam int CTRL_FINE_BIT  = 4;
	localparam int CTRL_ENC_BIT   = 5;
	localparam int CTRL_LANE_LSB  = 8;
	localparam int LANE_CNT_W     = 3;
	localparam logic [2:0] LANES_MAX = 3'h4;
	localparam logic [2:0] LANES_MIN = 3'h1;
	localparam int MF_W           = 16;
	localparam logic [15:0] MF_PERIOD_RST = 16'h0020;
	localparam logic       FINE_RST  = 1'h1;
	localparam int STAT_CGS_BIT   = 0;
	localparam int STAT_CAP_BIT   = 1;
	localparam int STAT_CNT_LSB   = 16;

	// ****************************************************************
	// AXI4-Lite responses
	// ****************************************************************
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Link encoding selection
	typedef enum logic [0:0] {
		SRWC_ENC_8B10B  = 1'b0,
		SRWC_ENC_64B66B = 1'b1
	} srwc_enc_t;

endpackage

// [rtl/srwc_tap_detect.sv]
// Delayed-tap SYSREF position detector and tap capture
`timescale 1ns/1ps
module srwc_tap_detect
	import srwc_pkg::*;
#(
	parameter int TAPS = EDGE_MAP_BITS
) (
	input  wire logic             mclk,
	input  wire logic             nrst,
	input  wire logic             sysref_s,
	input  wire logic             fine_step,
	input  wire logic [SEL_W-1:0] tap_sel,
	output logic      [TAPS-1:0]  edge_map,
	output logic                  cap_event
);

	logic [2*TAPS-1:0] chain_r;
	logic [TAPS-1:0]   tap;
	logic [TAPS-1:0]   live;
	logic [TAPS-1:0]   map_r;
	logic              sel_prev_r;
	logic              cap_r;
	wire               sel_tap;

	// Tap i sits i or 2*i steps down the chain, fine or coarse
	always_comb begin
		for (int i = 0; i < TAPS; i++) begin
			tap[i] = fine_step ? chain_r[i] : chain_r[2*i];
		end
	end

	// A tap is unsafe when a neighbour sees a different level
	always_comb begin
		live = '0;
		for (int i = 1; i < TAPS-1; i++) begin
			live[i] = (tap[i] ^ tap[i-1]) | (tap[i] ^ tap[i+1]);
		end
		live[0]      = 1'b1;
		live[TAPS-1] = 1'b1;
	end

	// Only the first sixteen taps can be selected
	assign sel_tap  = tap[tap_sel];
	assign edge_map = map_r;
	assign cap_event = cap_r;

	// Delay chain shifts on every rising clock edge
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			chain_r <= '0;
		end else begin
			chain_r <= {chain_r[2*TAPS-2:0], sysref_s};
		end
	end

	// Map refreshed only when an edge crosses the inner taps; otherwise it holds the last view
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			map_r      <= '1;
			sel_prev_r <= 1'b0;
			cap_r      <= 1'b0;
		end else begin
			if (|live[TAPS-2:1]) begin
				map_r <= live;
			end
			sel_prev_r <= sel_tap;
			cap_r      <= sel_tap & ~sel_prev_r;
		end
	end

	a_tap_fine_step: assert property (@(posedge mclk) disable iff (!nrst)
		fine_step |-> tap[1] == $past(chain_r[0]))
		else $error("fine tap spacing wrong");
	a_tap_coarse_step: assert property (@(posedge mclk) disable iff (!nrst)
		!fine_step |-> tap[1] == $past(chain_r[0], 2))
		else $error("coarse tap spacing wrong");
	a_map_refresh: assert property (@(posedge mclk) disable iff (!nrst)
		|live[TAPS-2:1] |=> map_r == $past(live))
		else $error("edge map not refreshed");
	a_cap_edge_sel: assert property (@(posedge mclk) disable iff (!nrst)
		cap_r |-> $past(sel_tap) && !$past(sel_tap, 2))
		else $error("capture not on selected tap edge");

endmodule

// [rtl/srwc_mf_counter.sv]
// Local multiframe / extended multiblock counter reset by SYSREF
`timescale 1ns/1ps
module srwc_mf_counter
	import srwc_pkg::*;
#(
	parameter int W = MF_W
) (
	input  wire logic         mclk,
	input  wire logic         nrst,
	input  wire logic         cap_event,
	input  wire logic [W-1:0] period,
	output logic      [W-1:0] count,
	output logic              boundary
);

	logic [W-1:0] cnt_r;
	wire          wrap;

	// Wrap at period-1; a zero period is held at zero
	assign wrap     = (cnt_r >= period - W'(1)) || (period == '0);
	assign count    = cnt_r;
	assign boundary = (cnt_r == '0);

	// SYSREF capture forces the counter phase deterministically
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt_r <= '0;
		end else if (cap_event) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= wrap ? '0 : cnt_r + W'(1);
		end
	end

	a_cap_resets_cnt: assert property (@(posedge mclk) disable iff (!nrst)
		cap_event |=> cnt_r == '0)
		else $error("capture did not reset counter");

endmodule

// [rtl/srwc_top.sv]
// SYSREF window capture block with AXI4-Lite register access
`timescale 1ns/1ps
module srwc_top
	import srwc_pkg::*;
#(
	parameter int AXI_AW = 10
) (
	input  wire logic              mclk,
	input  wire logic              nrst,
	input  wire logic              sysref_in,
	input  wire logic              link_sync_request_n,
	input  wire logic [AXI_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [AXI_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic [3:0]             lane_enable,
	output logic                   enc_64b66b,
	output logic                   cgs_request,
	output logic                   mf_boundary,
	output logic                   sysref_captured
);

	// ****************************************************************
	// Helpers
	// ****************************************************************
	function automatic logic is_mapped(input logic [7:0] idx);
		is_mapped = (idx == IDX_EDGE_MAP_LOW) || (idx == IDX_EDGE_MAP_MID) ||
			(idx == IDX_EDGE_MAP_HIGH) || (idx == IDX_LINK_CTRL) ||
			(idx == IDX_MF_PERIOD) || (idx == IDX_LINK_STATUS);
	endfunction

	function automatic logic [31:0] apply_strb(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = data[8*b +: 8];
			end
		end
		apply_strb = r;
	endfunction

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic [1:0] sref_sync_r;
	logic [1:0] sync_pin_r;

	// Two stages before anything looks at the pins
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			sref_sync_r <= 2'h0;
			sync_pin_r  <= 2'h3;
		end else begin
			sref_sync_r <= {sref_sync_r[0], sysref_in};
			sync_pin_r  <= {sync_pin_r[0], link_sync_request_n};
		end
	end

	// ****************************************************************
	// Control state
	// ****************************************************************
	logic [SEL_W-1:0]      tap_sel_r;
	logic                  fine_r;
	srwc_enc_t             enc_r;
	logic [LANE_CNT_W-1:0] lane_cnt_r;
	logic [MF_W-1:0]       period_r;
	logic                  cgs_r;
	logic                  cap_seen_r;
	logic [EDGE_MAP_BITS-1:0] edge_map;
	logic                  cap_event;
	logic [MF_W-1:0]       mf_count;
	logic                  mf_bound;

	srwc_tap_detect #(
		.TAPS      (EDGE_MAP_BITS)
	) u_detect (
		.mclk      (mclk),
		.nrst      (nrst),
		.sysref_s  (sref_sync_r[1]),
		.fine_step (fine_r),
		.tap_sel   (tap_sel_r),
		.edge_map  (edge_map),
		.cap_event (cap_event)
	);

	srwc_mf_counter #(
		.W         (MF_W)
	) u_mfcnt (
		.mclk      (mclk),
		.nrst      (nrst),
		.cap_event (cap_event),
		.period    (period_r),
		.count     (mf_count),
		.boundary  (mf_bound)
	);

	// ****************************************************************
	// AXI4-Lite write channel
	// ****************************************************************
	logic              aw_got_r;
	logic              w_got_r;
	logic [7:0]        aw_idx_r;
	logic [31:0]       wdata_r;
	logic [3:0]        wstrb_r;
	logic              bvalid_r;
	logic [1:0]        bresp_r;
	wire               aw_hs;
	wire               w_hs;
	wire               wr_go;
	wire [31:0]        ctrl_word;
	wire [31:0]        ctrl_new;
	wire [31:0]        period_new;
	wire [2:0]         lane_req;
	wire [2:0]         lane_fix;

	assign s_axi_awready = !aw_got_r && !bvalid_r;
	assign s_axi_wready  = !w_got_r && !bvalid_r;
	assign aw_hs = s_axi_awvalid && s_axi_awready;
	assign w_hs  = s_axi_wvalid && s_axi_wready;
	assign wr_go = aw_got_r && w_got_r && !bvalid_r;

	// Current control word and its updated image
	assign ctrl_word = {21'h0, lane_cnt_r, 2'h0, enc_r, fine_r, tap_sel_r};
	assign ctrl_new  = apply_strb(ctrl_word, wdata_r, wstrb_r);
	assign period_new = apply_strb({16'h0, period_r}, wdata_r, wstrb_r);

	// Lane count clamped to the reduced set of one to four
	assign lane_req = ctrl_new[CTRL_LANE_LSB +: LANE_CNT_W];
	assign lane_fix = (lane_req > LANES_MAX) ? LANES_MAX :
		((lane_req < LANES_MIN) ? LANES_MIN : lane_req);

	// Address and data may arrive in either order
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
			aw_idx_r <= 8'h00;
			wdata_r  <= 32'h0000_0000;
			wstrb_r  <= 4'h0;
		end else begin
			if (aw_hs) begin
				aw_got_r <= 1'b1;
				aw_idx_r <= s_axi_awaddr[9:2];
			end else if (wr_go) begin
				aw_got_r <= 1'b0;
			end
			if (w_hs) begin
				w_got_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end else if (wr_go) begin
				w_got_r <= 1'b0;
			end
		end
	end

	// Response follows both halves; unmapped writes get SLVERR
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			bvalid_r <= 1'b0;
			bresp_r  <= RESP_OKAY;
		end else if (wr_go) begin
			bvalid_r <= 1'b1;
			bresp_r  <= is_mapped(aw_idx_r) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_r <= 1'b0;
		end
	end

	// Writable settings; the edge map bytes are read only
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			tap_sel_r  <= '0;
			fine_r     <= FINE_RST;
			enc_r      <= SRWC_ENC_8B10B;
			lane_cnt_r <= LANES_MAX;
			period_r   <= MF_PERIOD_RST;
		end else if (wr_go && aw_idx_r == IDX_LINK_CTRL) begin
			tap_sel_r  <= ctrl_new[CTRL_SEL_LSB +: SEL_W];
			fine_r     <= ctrl_new[CTRL_FINE_BIT];
			enc_r      <= srwc_enc_t'(ctrl_new[CTRL_ENC_BIT]);
			lane_cnt_r <= lane_fix;
		end else if (wr_go && aw_idx_r == IDX_MF_PERIOD) begin
			period_r   <= period_new[MF_W-1:0];
		end
	end

	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp  = bresp_r;

	// ****************************************************************
	// AXI4-Lite read channel
	// ****************************************************************
	logic        rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0]  rresp_r;
	wire  [7:0]  ar_idx;
	wire         ar_hs;
	wire  [31:0] stat_word;
	logic [31:0] rd_mux;

	assign s_axi_arready = !rvalid_r;
	assign ar_hs  = s_axi_arvalid && s_axi_arready;
	assign ar_idx = s_axi_araddr[9:2];
	assign stat_word = {mf_count, 14'h0, cap_seen_r, cgs_r};

	// Low index holds the smallest delays
	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (ar_idx)
			IDX_EDGE_MAP_LOW:  rd_mux = {24'h0, edge_map[7:0]};
			IDX_EDGE_MAP_MID:  rd_mux = {24'h0, edge_map[15:8]};
			IDX_EDGE_MAP_HIGH: rd_mux = {24'h0, edge_map[23:16]};
			IDX_LINK_CTRL:     rd_mux = ctrl_word;
			IDX_MF_PERIOD:     rd_mux = {16'h0, period_r};
			IDX_LINK_STATUS:   rd_mux = stat_word;
			default:           rd_mux = 32'h0000_0000;
		endcase
	end

	// Data registered at the address handshake, held until taken
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			rvalid_r <= 1'b0;
			rdata_r  <= 32'h0000_0000;
			rresp_r  <= RESP_OKAY;
		end else if (ar_hs) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_mux;
			rresp_r  <= is_mapped(ar_idx) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_r <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata  = rdata_r;
	assign s_axi_rresp  = rresp_r;

	// ****************************************************************
	// Link-side status
	// ****************************************************************
	// The sync pin only matters in 8B/10B; 64B/66B aligns on sync headers
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cgs_r      <= 1'b0;
			cap_seen_r <= 1'b0;
		end else begin
			cgs_r <= (enc_r == SRWC_ENC_8B10B) && !sync_pin_r[1];
			if (cap_event) begin
				cap_seen_r <= 1'b1;
			end
		end
	end

	assign lane_enable = 4'((5'h01 << lane_cnt_r) - 5'h01);
	assign enc_64b66b  = (enc_r == SRWC_ENC_64B66B);
	assign cgs_request = cgs_r;
	assign mf_boundary = mf_bound;
	assign sysref_captured = cap_seen_r;

	// ****************************************************************
	// Checks
	// ****************************************************************
	a_map_ends_set: assert property (@(posedge mclk) disable iff (!nrst)
		edge_map[0] && edge_map[EDGE_MAP_BITS-1])
		else $error("edge map end bits not set");
	a_sync_ignored: assert property (@(posedge mclk) disable iff (!nrst)
		enc_r == SRWC_ENC_64B66B ##1 enc_r == SRWC_ENC_64B66B |-> !cgs_r)
		else $error("sync pin used in 64b66b mode");
	a_sync_cgs: assert property (@(posedge mclk) disable iff (!nrst)
		(enc_r == SRWC_ENC_8B10B && !sync_pin_r[1]) |=> cgs_r)
		else $error("cgs request missed");
	a_lanes_max: assert property (@(posedge mclk) disable iff (!nrst)
		lane_enable inside {4'h1, 4'h3, 4'h7, 4'hF})
		else $error("lane count out of range");
	a_read_map_low: assert property (@(posedge mclk) disable iff (!nrst)
		ar_hs && ar_idx == IDX_EDGE_MAP_LOW |=>
		s_axi_rvalid && s_axi_rdata == {24'h0, $past(edge_map[7:0])})
		else $error("edge map low read wrong");
	a_write_resp: assert property (@(posedge mclk) disable iff (!nrst)
		wr_go |=> s_axi_bvalid ##0 !s_axi_awready [*1])
		else $error("write response missing");
	a_sel_write: assert property (@(posedge mclk) disable iff (!nrst)
		wr_go && aw_idx_r == IDX_LINK_CTRL && wstrb_r[0] |=>
		tap_sel_r == $past(wdata_r[SEL_W-1:0]))
		else $error("tap select not written");

endmodule

// [tb/srwc_far_end.sv]
// Behavioural far side: SYSREF source and link receiver sync request
`timescale 1ns/1ps
module srwc_far_end #(
	parameter int PULSE_W = 6,
	parameter int PERIOD  = 16
) (
	input  wire logic mclk,
	input  wire logic fire,
	input  wire logic periodic,
	input  wire logic want_sync,
	output logic      sysref_out,
	output logic      sync_n
);
	int cnt = 1000;

	// ****************************************************************
	// SYSREF source
	// ****************************************************************
	// One shot on request, or a train whose period divides the frame
	always @(posedge mclk) begin
		if (fire || (periodic && cnt >= PERIOD - 1))
			cnt <= 0;
		else if (cnt < 1000)
			cnt <= cnt + 1;
	end
	assign sysref_out = (cnt < PULSE_W);

	// ****************************************************************
	// Receiver sync request
	// ****************************************************************
	// Held low only while the receiver wants code group sync
	assign sync_n = !want_sync;
endmodule

// [tb/srwc_top_bench.sv]
// Self-checking bench for the SYSREF window capture block
`timescale 1ns/1ps
module srwc_top_bench;
	import srwc_pkg::*;
	localparam logic [9:0] A_LO = {IDX_EDGE_MAP_LOW, 2'b00};
	localparam logic [9:0] A_MID = {IDX_EDGE_MAP_MID, 2'b00};
	localparam logic [9:0] A_HI = {IDX_EDGE_MAP_HIGH, 2'b00};
	localparam logic [9:0] A_CTRL = {IDX_LINK_CTRL, 2'b00};
	localparam logic [9:0] A_MF = {IDX_MF_PERIOD, 2'b00};
	localparam logic [9:0] A_STAT = {IDX_LINK_STATUS, 2'b00};
	localparam logic [9:0] A_NONE = 10'h3FC;
	logic        mclk = 1'b0;
	logic        nrst = 1'b0;
	logic        sysref_in, sync_n, fire = 1'b0, periodic = 1'b0;
	logic        want_sync = 1'b0;
	logic [9:0]  awaddr = 10'h0, araddr = 10'h0;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0]  wstrb = 4'hF, lane_enable;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp, r;
	logic        enc_64b66b, cgs_request, mf_boundary, sysref_captured;
	logic [31:0] d;
	int          n_fail = 0, num_checks = 0, cycles = 0;

	// Clock of 100 ns period
	always #50 mclk = !mclk;

	srwc_far_end i_srwc_far_end (.mclk(mclk), .fire(fire),
		.periodic(periodic), .want_sync(want_sync),
		.sysref_out(sysref_in), .sync_n(sync_n));

	srwc_top i_srwc_top (.mclk(mclk), .nrst(nrst), .sysref_in(sysref_in),
		.link_sync_request_n(sync_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .lane_enable(lane_enable),
		.enc_64b66b(enc_64b66b), .cgs_request(cgs_request),
		.mf_boundary(mf_boundary), .sysref_captured(sysref_captured));

	// ****************************************************************
	// Reporting
	// ****************************************************************
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Hang guard, far above the thousand or so cycles the tests need
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			$display("[ERR] run time expected end seen timeout");
			wrap_up();
		end
	end

	// ****************************************************************
	// AXI4-Lite master
	// ****************************************************************
	// Ready is sampled at the negedge, where inputs are already stable
	task automatic axi_wr(input logic [9:0] a, input logic [31:0] v);
		logic aw_on, w_on;
		aw_on = 1'b1;
		w_on = 1'b1;
		@(posedge mclk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (aw_on || w_on) begin
			@(negedge mclk);
			if (awready)
				aw_on = 1'b0;
			if (wready)
				w_on = 1'b0;
			@(posedge mclk);
			if (!aw_on)
				awvalid <= 1'b0;
			if (!w_on)
				wvalid <= 1'b0;
		end
		do @(negedge mclk); while (!bvalid);
		r = bresp;
		@(posedge mclk);
		bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [9:0] a);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(negedge mclk); while (!arready);
		@(posedge mclk);
		arvalid <= 1'b0;
		do @(negedge mclk); while (!rvalid);
		d = rdata;
		r = rresp;
		@(posedge mclk);
		rready <= 1'b0;
	endtask

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	// Reset values, read-only map and an unmapped place
	task automatic t_reset_bus;
		chk("lanes", 32'h F, lane_enable);
		chk("enc", 32'h0, enc_64b66b);
		chk("captured", 32'h0, sysref_captured);
		axi_rd(A_CTRL);
		chk("ctrl", 32'h410, d & 32'hFFFFFFF0);
		axi_rd(A_MF);
		chk("mf period", 32'h20, d);
		axi_wr(A_LO, 32'h0);
		chk("map wr resp", 32'(RESP_OKAY), r);
		axi_rd(A_LO);
		chk("map lo", 32'hFF, d);
		axi_rd(A_NONE);
		chk("bad rd resp", 32'(RESP_SLVERR), r);
		chk("bad rd data", 32'h0, d);
		axi_wr(A_NONE, 32'h1);
		chk("bad wr resp", 32'(RESP_SLVERR), r);
		$display("reset and bus done");
	endtask

	// Cycles from a single SYSREF pulse to the counter restart
	task automatic lat(input logic [3:0] tap, input logic fine,
		output int n);
		axi_wr(A_CTRL, {21'h0, 3'h4, 3'h0, fine, tap});
		repeat (60) @(posedge mclk);
		fire <= 1'b1;
		@(posedge mclk);
		fire <= 1'b0;
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (!mf_boundary && n < 200);
	endtask

	task automatic t_taps;
		int a, b, c, e, f;
		axi_wr(A_MF, 32'hFFFF);
		lat(4'h0, 1'b1, a);
		lat(4'h5, 1'b1, b);
		lat(4'hF, 1'b1, c);
		lat(4'h0, 1'b0, e);
		lat(4'h5, 1'b0, f);
		chk("fine tap 5", 32'd5, 32'(b - a));
		chk("fine tap 15", 32'd15, 32'(c - a));
		chk("coarse tap 5", 32'd10, 32'(f - e));
		chk("captured", 32'h1, sysref_captured);
		axi_rd(A_STAT);
		chk("stat cap", 32'h1, 32'(d[STAT_CAP_BIT]));
		$display("tap select done");
	endtask

	// Counter restart by SYSREF, then wrap at the programmed period
	task automatic t_period;
		int n;
		axi_wr(A_MF, 32'h8);
		axi_wr(A_CTRL, {21'h0, 3'h4, 3'h0, 1'b1, 4'h0});
		repeat (60) @(posedge mclk);
		fire <= 1'b1;
		@(posedge mclk);
		fire <= 1'b0;
		// Capture lands five edges on, whatever the free-running phase
		repeat (5) @(posedge mclk);
		@(negedge mclk);
		chk("mf restart", 32'h1, 32'(mf_boundary));
		n = 0;
		do begin
			@(negedge mclk);
			n++;
		end while (!mf_boundary && n < 100);
		chk("mf wrap", 32'd8, 32'(n));
		$display("multiframe done");
	endtask

	// Sync request honoured in 8B/10B only, three edges late
	task automatic t_sync;
		@(posedge mclk);
		want_sync <= 1'b1;
		repeat (3) @(negedge mclk);
		chk("cgs early", 32'h0, cgs_request);
		@(negedge mclk);
		chk("cgs", 32'h1, cgs_request);
		axi_rd(A_STAT);
		chk("stat cgs", 32'h1, 32'(d[STAT_CGS_BIT]));
		axi_wr(A_CTRL, {21'h0, 3'h4, 3'h1, 1'b1, 4'h0});
		repeat (5) @(negedge mclk);
		chk("enc", 32'h1, enc_64b66b);
		chk("cgs 64b", 32'h0, cgs_request);
		@(posedge mclk);
		want_sync <= 1'b0;
		$display("sync done");
	endtask

	// Lane count clamped into 1..4, thermometer coded
	task automatic t_lanes;
		logic [2:0] lv[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
		logic [3:0] le[6] = '{4'h1, 4'h1, 4'h3, 4'h7, 4'hF, 4'hF};
		for (int i = 0; i < 6; i++) begin
			axi_wr(A_CTRL, {21'h0, lv[i], 3'h0, 1'b1, 4'h0});
			@(negedge mclk);
			chk("lanes", 32'(le[i]), lane_enable);
		end
		$display("lanes done");
	endtask

	// Edge map under a running SYSREF
	task automatic t_map;
		axi_wr(A_CTRL, {21'h0, 3'h4, 3'h0, 1'b1, 4'h0});
		@(posedge mclk);
		periodic <= 1'b1;
		repeat (200) @(posedge mclk);
		axi_rd(A_LO);
		chk("map bit 0", 32'h1, 32'(d[0]));
		axi_rd(A_MID);
		chk("map mid live", 32'h1, 32'(d[7:0] !== 8'hFF));
		axi_rd(A_HI);
		chk("map bit 23", 32'h1, 32'(d[7]));
		chk("map upper", 32'h0, d & 32'hFFFFFF00);
		$display("edge map done");
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		t_reset_bus();
		t_taps();
		t_period();
		t_sync();
		t_lanes();
		t_map();
		wrap_up();
	end
endmodule
